/* File: bench/pif_event_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Peripheral side: one-cycle event pulses and toggled levels
module pif_event_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [19:0] fire,
  output var  logic [19:0] ev
);
  always @(posedge aclk) begin
    if (!aresetn) begin
      ev <= 20'h00000;
    end else begin
      // Single-cycle events in bits 15:0; bits 19:16 toggle as levels
      ev[15:0] <= fire[15:0]; // Event strobes; capture and match strobes in bits 15:8
      ev[19:16] <= ev[19:16] ^ fire[19:16]; // Comparator and buffer levels
    end
  end
endmodule // pif_event_model

`default_nettype wire

/* File: bench/pif_periph_irq_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module pif_periph_irq_assertions #(
  parameter ADDR_W = 8
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              osc_fail,
  input wire logic              usb_request,
  input wire logic              low_voltage,
  input wire logic              timer_d_match,
  input wire logic              async_port_b_rx_full,
  input wire logic              async_port_b_tx_empty,
  input wire logic              irq_high,
  input wire logic              irq_low
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic rd_two;
  logic rd_three;
  logic rd_stat;
  assign rd_two = s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00;
  assign rd_three = s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04;
  assign rd_stat = s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h10;

  reset_quiet_a: assert property (
    $rose(aresetn) |-> !(s_axi_awready || s_axi_bvalid || s_axi_rvalid || irq_high || irq_low))
    else $error("outputs busy right after reset");
  osc_flag_a: assert property (
    rd_two && $past(osc_fail) |=> s_axi_rdata[7]) else $error("oscillator flag missing");
  usb_flag_a: assert property (
    rd_two && $past(usb_request) |=> s_axi_rdata[4]) else $error("usb flag missing");
  low_volt_a: assert property (
    rd_two && $past(low_voltage) |=> s_axi_rdata[2]) else $error("low voltage flag missing");
  timer_match_a: assert property (
    rd_three && $past(timer_d_match) |=> s_axi_rdata[3]) else $error("timer match flag missing");
  rx_mirror_a: assert property (
    rd_three && $stable(async_port_b_rx_full) && $past(async_port_b_rx_full, 2) == async_port_b_rx_full
    |=> s_axi_rdata[5] == $past(async_port_b_rx_full)) else $error("receive flag not mirrored");
  tx_mirror_a: assert property (
    rd_three && $stable(async_port_b_tx_empty) && $past(async_port_b_tx_empty, 2) == async_port_b_tx_empty
    |=> s_axi_rdata[4] == $past(async_port_b_tx_empty)) else $error("transmit flag not mirrored");
  status_irq_a: assert property (
    rd_stat |=> s_axi_rdata[1:0] == {$past(irq_low), $past(irq_high)}) else $error("status differs from lines");
endmodule // pif_periph_irq_assertions

`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pif_defs.vh"

module tb_top;
  localparam logic [1:0] ok = `PIF_RESP_OKAY;
  logic aclk = 0, aresetn = 0, hi, lo, e;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq_high, irq_low;
  logic [7:0] awaddr = 0, araddr = 0, a, p, cmode = 0, pf1 = 0, en2 = 0, en3 = 0;
  logic [31:0] wdata = 0, rdata, v;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp;
  logic [19:0] fire = 0, ev;
  logic [23:0] prio = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int n_errors = 0, checks = 0, seed = 31, cyc = 0, i, j, m;
  int fb[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 16, 17, 18, 19};
  int bp[12] = '{7, 4, 3, 2, 1, 7, 6, 3, 5, 6, 5, 4};

  always #5 aclk = ~aclk;

  pif_event_model peer (.aclk(aclk), .aresetn(aresetn), .fire(fire), .ev(ev));

  pif_periph_irq dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .osc_fail(ev[0]), .comparator_a_out(ev[16]), .comparator_b_out(ev[17]), .usb_request(ev[1]),
    .sync_port_a_collision(ev[2]), .low_voltage(ev[3]), .timer_c_overflow(ev[4]), .capcomp_mode(cmode),
    .capcomp_capture(ev[11:8]), .capcomp_match(ev[15:12]), .sync_port_b_done(ev[5]),
    .sync_port_b_collision(ev[6]), .async_port_b_rx_full(ev[18]), .async_port_b_tx_empty(ev[19]),
    .timer_d_match(ev[7]), .periph_flags_one(pf1), .periph_enables_two(en2), .periph_enables_three(en3),
    .periph_priority(prio), .irq_high(irq_high), .irq_low(irq_low));

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d, input logic s, input logic [1:0] r);
    bq.push_back(r);
    awaddr <= ad; wdata <= {24'h0, d}; wstrb <= {3'h0, s};
    awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [7:0] d, input logic [1:0] r);
    rq.push_back({r, 24'h0, d});
    araddr <= ad; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    @(posedge aclk);
  endtask

  task automatic pulse(input logic [19:0] f, input logic slow);
    fire <= f;
    @(posedge aclk);
    fire <= 0;
    @(posedge aclk);
    if (slow) @(posedge aclk);
  endtask

  task automatic final_report;
    $display("n_errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Response checker: oldest note against each answer
  always @(posedge aclk) begin
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    if (bvalid && bready) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      final_report;
    end
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (i = 0; i < 5; i++) rd(8'(i * 4), 8'h00, ok);
    rd(8'h14, 8'h00, `PIF_RESP_SLVERR);
    wr(8'h20, 8'hFF, 1'b1, `PIF_RESP_SLVERR);
    for (i = 0; i < 6; i++) begin
      v = $random(seed);
      a = (i % 2) ? 8'h08 : 8'h00;
      wr(a, v[7:0], 1'b1, ok);
      wr(a, v[15:8], 1'b0, ok);
      rd(a, v[7:0], ok);
    end
    wr(8'h00, 8'h00, 1'b1, ok);
    wr(8'h04, 8'hFF, 1'b1, ok);
    rd(8'h04, 8'hCF, ok);
    wr(8'h04, 8'h00, 1'b1, ok);
    for (i = 0; i < 12; i++) begin
      a = (i inside {5, 6, 7, 10, 11}) ? 8'h04 : 8'h00;
      pulse(20'h1 << fb[i], i > 7);
      rd(a, 8'h01 << bp[i], ok);
      if (i < 10) wr(a, 8'h00, 1'b1, ok);
      else pulse(20'h1 << fb[i], 1'b1);
      rd(a, 8'h00, ok);
    end
    for (m = 0; m < 4; m++) begin
      cmode <= {4{m[1:0]}};
      for (j = 0; j < 2; j++) begin
        e = (m == 1 && j == 0) || (m == 2 && j == 1);
        pulse(20'hF << (8 + 4 * j), 1'b0);
        rd(8'h00, {7'h0, e}, ok);
        rd(8'h04, {5'h0, {3{e}}}, ok);
        wr(8'h00, 8'h00, 1'b1, ok);
        wr(8'h04, 8'h00, 1'b1, ok);
      end
    end
    for (j = 0; j < 2; j++) begin
      v = $random(seed);
      pf1 <= v[7:0]; en2 <= v[23:16]; en3 <= v[23:16]; prio <= {v[31:8]};
      wr(8'h08, v[15:8], 1'b1, ok);
      p = v[7:0] & v[15:8];
      for (m = 0; m < 8; m++) begin
        hi = m[2] ? m[0] & (|(p & v[31:24])) : m[0] & m[1] & (|p);
        lo = m[2] & m[0] & m[1] & (|(p & ~v[31:24]));
        wr(8'h0C, m[7:0], 1'b1, ok);
        rd(8'h0C, m[7:0], ok);
        rd(8'h10, {6'h0, lo, hi}, ok);
        chk({32'h0, irq_low, irq_high}, {32'h0, lo, hi});
      end
    end
    final_report;
  end
endmodule // tb_top

bind pif_periph_irq pif_periph_irq_assertions #(.ADDR_W(ADDR_W)) chk_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_araddr(s_axi_araddr), .s_axi_rdata(s_axi_rdata), .osc_fail(osc_fail), .usb_request(usb_request),
  .low_voltage(low_voltage), .timer_d_match(timer_d_match), .async_port_b_rx_full(async_port_b_rx_full),
  .async_port_b_tx_empty(async_port_b_tx_empty), .irq_high(irq_high), .irq_low(irq_low));

`default_nettype wire

/* File: logic/pif_change_detect.v */
`timescale 1ns/1ps
`default_nettype none

module pif_change_detect #(
  parameter W = 2
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] level,
  output wire [W-1:0] changed
);

  reg [W-1:0] last;
  reg         armed;

  // No change is reported before the first level is captured
  assign changed = armed ? (level ^ last) : {W{1'b0}};

  always @(posedge aclk) begin
    if (!aresetn) begin
      last  <= {W{1'b0}};
      armed <= 1'b0;
    end else begin
      last  <= level;
      armed <= 1'b1;
    end
  end

endmodule // pif_change_detect

`default_nettype wire

/* File: logic/pif_defs.vh */
`ifndef PIF_DEFS_VH
`define PIF_DEFS_VH

// Register byte offsets
`define PIF_OFF_FLAGS_TWO    8'h00
`define PIF_OFF_FLAGS_THREE  8'h04
`define PIF_OFF_ENABLES_ONE  8'h08
`define PIF_OFF_CONTROL      8'h0C
`define PIF_OFF_STATUS       8'h10

// Reset values
`define PIF_RST_FLAGS        8'h00
`define PIF_RST_ENABLES      8'h00
`define PIF_RST_CONTROL      3'h0

// Second flag register fields
`define PIF_F2_OSC_FAIL      7
`define PIF_F2_COMP_B        6
`define PIF_F2_COMP_A        5
`define PIF_F2_USB           4
`define PIF_F2_SYNC_A_COLL   3
`define PIF_F2_LOW_VOLT      2
`define PIF_F2_TIMER_C_OVF   1
`define PIF_F2_CAPCOMP_B     0

// Third flag register fields
`define PIF_F3_SYNC_B_DONE   7
`define PIF_F3_SYNC_B_COLL   6
`define PIF_F3_ASYNC_B_RX    5
`define PIF_F3_ASYNC_B_TX    4
`define PIF_F3_TIMER_D_MATCH 3

// Control register fields
`define PIF_CTL_GLOBAL       0
`define PIF_CTL_PERIPH       1
`define PIF_CTL_PRIORITY     2

// Status register fields
`define PIF_ST_IRQ_HIGH      0
`define PIF_ST_IRQ_LOW       1

// Capture/compare unit modes
`define PIF_CC_MODE_OFF      2'h0
`define PIF_CC_MODE_CAPTURE  2'h1
`define PIF_CC_MODE_COMPARE  2'h2
`define PIF_CC_MODE_PWM      2'h3

// Bus response codes
`define PIF_RESP_OKAY        2'h0
`define PIF_RESP_SLVERR      2'h2

`endif

/* File: logic/pif_periph_irq.v */
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pif_defs.vh"

// How it works
// RULE_01: Oscillator failure pulse sets flag two bit 7 until software clears it.
// RULE_02: Any change of either comparator output sets its flag until cleared.
// RULE_03: USB interrupt request sets flag two bit 4 until written to zero.
// RULE_04: First sync port collision sets flag two bit 3 until cleared.
// RULE_05: Low-voltage report sets flag two bit 2; zero while supply is good. The code holds it set until software clears it.
// RULE_06: Timer C overflow sets flag two bit 1 until software clears it.
// RULE_07: Capture/compare flags set on capture in capture mode; ignored in PWM mode.
// RULE_08: In compare mode capture/compare flags set on timer match, held until cleared.
// RULE_09: Second sync port completion sets flag three bit 7 until cleared.
// RULE_10: Second sync port collision sets flag three bit 6 until cleared.
// RULE_11: Receive flag is read-only, follows receive buffer full, clears on buffer read.
// RULE_12: Transmit flag follows transmit buffer empty, clears when buffer written.
// RULE_13: Timer D period match sets flag three bit 3 until cleared.
// RULE_14: Both flag registers and first enable register reset to zero.
// RULE_15: Without priority, peripheral requests need the peripheral global enable set.
// RULE_16: First enable register masks the eight first-group sources, one means enabled.
// RULE_17: Flags set regardless of any enable bit, allowing polling.
// RULE_18: With priority on, peripheral global enable gates only low-priority requests.
// RULE_19: Request raised when any flag and its enable are both set, then gated.
module pif_periph_irq #(
  parameter ADDR_W = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              osc_fail,
  input  wire              comparator_a_out,
  input  wire              comparator_b_out,
  input  wire              usb_request,
  input  wire              sync_port_a_collision,
  input  wire              low_voltage,
  input  wire              timer_c_overflow,
  input  wire [7:0]        capcomp_mode,
  input  wire [3:0]        capcomp_capture,
  input  wire [3:0]        capcomp_match,
  input  wire              sync_port_b_done,
  input  wire              sync_port_b_collision,
  input  wire              async_port_b_rx_full,
  input  wire              async_port_b_tx_empty,
  input  wire              timer_d_match,
  input  wire [7:0]        periph_flags_one,
  input  wire [7:0]        periph_enables_two,
  input  wire [7:0]        periph_enables_three,
  input  wire [23:0]       periph_priority,
  output reg               irq_high,
  output reg               irq_low
);

  // Register selects
  localparam SEL_NONE   = 3'd0;
  localparam SEL_FLAGS2 = 3'd1;
  localparam SEL_FLAGS3 = 3'd2;
  localparam SEL_EN1    = 3'd3;
  localparam SEL_CTRL   = 3'd4;
  localparam SEL_STATUS = 3'd5;

  // Maps a byte address to a register select
  function [2:0] pif_decode;
    input [ADDR_W-1:0] addr;
    reg   [7:0]        off;
    begin
      off = {addr[7:2], 2'b00};
      case (off)
        `PIF_OFF_FLAGS_TWO:   pif_decode = SEL_FLAGS2;
        `PIF_OFF_FLAGS_THREE: pif_decode = SEL_FLAGS3;
        `PIF_OFF_ENABLES_ONE: pif_decode = SEL_EN1;
        `PIF_OFF_CONTROL:     pif_decode = SEL_CTRL;
        `PIF_OFF_STATUS:      pif_decode = SEL_STATUS;
        default:              pif_decode = SEL_NONE;
      endcase
    end
  endfunction

  // Capture/compare event qualified by the unit's mode
  function pif_cc_event;
    input [1:0] mode;
    input       capture;
    input       match;
    begin
      case (mode)
        `PIF_CC_MODE_CAPTURE: pif_cc_event = capture;
        `PIF_CC_MODE_COMPARE: pif_cc_event = match;
        default:              pif_cc_event = 1'b0;
      endcase
    end
  endfunction

  reg              aw_full;
  reg              w_full;
  reg [ADDR_W-1:0] awaddr_q;
  reg [31:0]       wdata_q;
  reg [3:0]        wstrb_q;
  reg [7:0]        periph_enables_one;
  reg [2:0]        control;
  reg              async_b_rx;
  reg              async_b_tx;
  reg [31:0]       rd_word;
  reg              rd_ok;

  wire              aw_take;
  wire              w_take;
  wire              ar_take;
  wire              have_aw;
  wire              have_w;
  wire              wr_fire;
  wire [ADDR_W-1:0] wr_addr;
  wire [31:0]       wr_data;
  wire [3:0]        wr_strb;
  wire [2:0]        wr_sel;
  wire              wr_lane;
  wire              next_aw_full;
  wire              next_w_full;
  wire              next_bvalid;
  wire              next_rvalid;
  wire [1:0]        comp_changed;
  wire [3:0]        cc_set;
  wire [13:0]       sticky_set;
  wire [13:0]       sticky_wdata;
  wire              sticky_we2;
  wire              sticky_we3;
  wire [13:0]       sticky;
  wire [7:0]        periph_flags_two;
  wire [7:0]        periph_flags_three;
  wire [23:0]       pending;
  wire              any_pending;
  wire              any_high;
  wire              any_low;
  wire              next_irq_high;
  wire              next_irq_low;

  // Write and read channel handshakes
  assign aw_take      = s_axi_awvalid & s_axi_awready;
  assign w_take       = s_axi_wvalid & s_axi_wready;
  assign ar_take      = s_axi_arvalid & s_axi_arready;
  assign have_aw      = aw_full | aw_take;
  assign have_w       = w_full | w_take;
  assign wr_fire      = have_aw & have_w & ~s_axi_bvalid;
  assign wr_addr      = aw_full ? awaddr_q : s_axi_awaddr;
  assign wr_data      = w_full ? wdata_q : s_axi_wdata;
  assign wr_strb      = w_full ? wstrb_q : s_axi_wstrb;
  assign wr_sel       = pif_decode(wr_addr);
  assign wr_lane      = wr_fire & wr_strb[0];
  assign next_aw_full = have_aw & ~wr_fire;
  assign next_w_full  = have_w & ~wr_fire;
  assign next_bvalid  = wr_fire | (s_axi_bvalid & ~s_axi_bready);
  assign next_rvalid  = ar_take | (s_axi_rvalid & ~s_axi_rready);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      awaddr_q      <= {ADDR_W{1'b0}};
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PIF_RESP_OKAY;
    end else begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      s_axi_awready <= ~next_aw_full & ~next_bvalid;
      s_axi_wready  <= ~next_w_full & ~next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bresp <= (wr_sel == SEL_NONE) ? `PIF_RESP_SLVERR : `PIF_RESP_OKAY;
      end
    end
  end

  // Comparator output changes become one-cycle events
  pif_change_detect #(
    .W (2)
  ) u_comp_change (
    .aclk    (aclk),
    .aresetn (aresetn),
    .level   ({comparator_b_out, comparator_a_out}),
    .changed (comp_changed)
  );

  // Units b, c, d, e in bits 0 to 3
  assign cc_set[0] = pif_cc_event(capcomp_mode[1:0], capcomp_capture[0], capcomp_match[0]); // [RULE_07] [RULE_08]
  assign cc_set[1] = pif_cc_event(capcomp_mode[3:2], capcomp_capture[1], capcomp_match[1]); // [RULE_07] [RULE_08]
  assign cc_set[2] = pif_cc_event(capcomp_mode[5:4], capcomp_capture[2], capcomp_match[2]); // [RULE_07] [RULE_08]
  assign cc_set[3] = pif_cc_event(capcomp_mode[7:6], capcomp_capture[3], capcomp_match[3]); // [RULE_07] [RULE_08]

  // Sticky flags: 13:6 second register, 5:4 third bits 7:6, 3:0 third bits 3:0
  assign sticky_set[13] = osc_fail;              // [RULE_01] [RULE_17]
  assign sticky_set[12] = comp_changed[1];       // [RULE_02]
  assign sticky_set[11] = comp_changed[0];       // [RULE_02]
  assign sticky_set[10] = usb_request;           // [RULE_03]
  assign sticky_set[9]  = sync_port_a_collision; // [RULE_04]
  assign sticky_set[8]  = low_voltage;           // [RULE_05]
  assign sticky_set[7]  = timer_c_overflow;      // [RULE_06]
  assign sticky_set[6]  = cc_set[0];             // [RULE_07]
  assign sticky_set[5]  = sync_port_b_done;      // [RULE_09]
  assign sticky_set[4]  = sync_port_b_collision; // [RULE_10]
  assign sticky_set[3]  = timer_d_match;         // [RULE_13]
  assign sticky_set[2]  = cc_set[3];             // [RULE_07]
  assign sticky_set[1]  = cc_set[2];             // [RULE_07]
  assign sticky_set[0]  = cc_set[1];             // [RULE_07]

  assign sticky_we2   = wr_lane & (wr_sel == SEL_FLAGS2);
  assign sticky_we3   = wr_lane & (wr_sel == SEL_FLAGS3);
  assign sticky_wdata = {sticky_we2 ? wr_data[7:0] : sticky[13:6],
                         sticky_we3 ? wr_data[7:6] : sticky[5:4],
                         sticky_we3 ? wr_data[3:0] : sticky[3:0]};

  pif_sticky_flags #(
    .W (14)
  ) u_flags (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (sticky_set),
    .wr_en   (sticky_we2 | sticky_we3),
    .wr_data (sticky_wdata),
    .flags   (sticky)
  ); // [RULE_14]

  assign periph_flags_two   = sticky[13:6];
  assign periph_flags_three = {sticky[5:4], async_b_rx, async_b_tx, sticky[3:0]};

  // Buffer status mirrors, enable and control registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      async_b_rx         <= 1'b0;                // [RULE_14]
      async_b_tx         <= 1'b0;
      periph_enables_one <= `PIF_RST_ENABLES;    // [RULE_14]
      control            <= `PIF_RST_CONTROL;
    end else begin
      async_b_rx <= async_port_b_rx_full;        // [RULE_11]
      async_b_tx <= async_port_b_tx_empty;       // [RULE_12]
      if (wr_lane && wr_sel == SEL_EN1) begin
        periph_enables_one <= wr_data[7:0];      // [RULE_16]
      end
      if (wr_lane && wr_sel == SEL_CTRL) begin
        control <= wr_data[2:0];
      end
    end
  end

  // Request combining and priority gating
  assign pending     = {periph_flags_one, periph_flags_two, periph_flags_three} &
                       {periph_enables_one, periph_enables_two, periph_enables_three}; // [RULE_19] [RULE_16]
  assign any_pending = |pending;
  assign any_high    = |(pending & periph_priority);
  assign any_low     = |(pending & ~periph_priority);

  assign next_irq_high = control[`PIF_CTL_PRIORITY]
                       ? (control[`PIF_CTL_GLOBAL] & any_high)
                       : (control[`PIF_CTL_GLOBAL] & control[`PIF_CTL_PERIPH] & any_pending); // [RULE_15]
  assign next_irq_low  = control[`PIF_CTL_PRIORITY] & control[`PIF_CTL_GLOBAL] &
                         control[`PIF_CTL_PERIPH] & any_low; // [RULE_18]

  // Request lines come straight from flip-flops
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_high <= 1'b0;
      irq_low  <= 1'b0;
    end else begin
      irq_high <= next_irq_high; // [RULE_19]
      irq_low  <= next_irq_low;
    end
  end

  // Read data selection
  always @* begin
    rd_word = 32'h00000000;
    rd_ok   = 1'b1;
    case (pif_decode(s_axi_araddr))
      SEL_FLAGS2: begin
        rd_word[7:0] = periph_flags_two;
      end
      SEL_FLAGS3: begin
        rd_word[7:0] = periph_flags_three;
      end
      SEL_EN1: begin
        rd_word[7:0] = periph_enables_one;
      end
      SEL_CTRL: begin
        rd_word[2:0] = control;
      end
      SEL_STATUS: begin
        rd_word[`PIF_ST_IRQ_HIGH] = irq_high;
        rd_word[`PIF_ST_IRQ_LOW]  = irq_low;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // Read response held until taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PIF_RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `PIF_RESP_OKAY : `PIF_RESP_SLVERR;
      end
    end
  end

endmodule // pif_periph_irq

`default_nettype wire

/* File: logic/pif_sticky_flags.v */
`timescale 1ns/1ps
`default_nettype none

module pif_sticky_flags #(
  parameter W = 8
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] set,
  input  wire         wr_en,
  input  wire [W-1:0] wr_data,
  output reg  [W-1:0] flags
);

  wire [W-1:0] next_flags;

  // A set in the same cycle as a clearing write wins
  assign next_flags = set | (wr_en ? wr_data : flags);

  always @(posedge aclk) begin
    if (!aresetn) begin
      flags <= {W{1'b0}};
    end else begin
      flags <= next_flags;
    end
  end

endmodule // pif_sticky_flags

`default_nettype wire
